// ===== design/cif_primary_request_event_flags.sv
// first-request event flags, masks, request pin and apb slave
//
// Summary of operation
// R1 - secondary request rising edge starts processor firmware
// R2 - either request selectable onto general pin
// R3 - after reset only boot source unmasked
// R4 - boot finish drives request pin low
// R5 - host interface error rise sets bit 12
// R6 - main clock fail rise sets bit 9
// R7 - boot complete rise sets bit 7
// R8 - clock error rises set bits 14-12
// R9 - loop lock either edge sets bits 9,8
// R10 - loop reference lost rise sets bits 6,5
// R11 - accessory detect events set bits 9,8
// R12 - headphone sense rise sets bit 0
// R13 - clamp b fall bit 11, rise 10
// R14 - clamp a fall bit 5, rise 4
// R15 - jack c fall bit 9, rise 8
// R16 - jack b fall bit 3, rise 2
// R17 - jack a fall bit 1, rise 0
// R18 - flags reset zero, clear by writing one
// R19 - request is or of all flags
// R20 - masked source sets no flag, no request
// R21 - pin active low, invertible, push-pull or open-drain
// R22 - new event beats same-cycle clear
// R23 - sources synchronised, edges found by comparison
`timescale 1ns/1ps
`include "cif_defines.svh"
`default_nettype none

module cif_primary_request_event_flags
    import cif_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources, asynchronous levels
    input wire cif_src_t src_in,
    // second request from the companion register set
    input wire logic secondary_request,
    // request pin, general pin and firmware start
    output logic primary_request_pin_out,
    output logic primary_request_pin_oe,
    output logic gpio_request_out,
    output logic dsp_start
);

    cif_state_t st;
    cif_state_t nx;

    cif_src_t rise;
    cif_src_t fall;
    logic [15:0] evt_sys;
    logic [15:0] evt_clk;
    logic [15:0] evt_acc;
    logic [15:0] evt_jack;
    logic [15:0] clr_sys;
    logic [15:0] clr_clk;
    logic [15:0] clr_acc;
    logic [15:0] clr_jack;
    logic [13:0] idx;
    logic aligned;
    logic mapped;
    logic wr;
    logic setup_rd;
    logic req;
    logic level;
    logic [31:0] rd_mux;

    assign idx = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign wr = psel && penable && pwrite && mapped;
    assign setup_rd = psel && !penable && !pwrite;

    // address decode
    always_comb begin
        unique case (idx)
            `CIF_IDX_SYS, `CIF_IDX_CLK, `CIF_IDX_ACC, `CIF_IDX_JACK,
            `CIF_IDX_MSK_SYS, `CIF_IDX_MSK_CLK, `CIF_IDX_MSK_ACC, `CIF_IDX_MSK_JACK,
            `CIF_IDX_CFG, `CIF_IDX_RAW: begin
                mapped = aligned;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // edges between the synchronised sample and the one before it
    assign rise = cif_src_t'(st.s2 & ~st.s3); // R23
    assign fall = cif_src_t'(~st.s2 & st.s3); // R23

    // map edges onto flag positions
    always_comb begin
        evt_sys = 16'h0000;
        evt_clk = 16'h0000;
        evt_acc = 16'h0000;
        evt_jack = 16'h0000;
        evt_sys[`CIF_B_HOST_IF_ERR] = rise.host_if_error; // R5
        evt_sys[`CIF_B_CLK_FAIL] = rise.main_clock_fail; // R6
        evt_sys[`CIF_B_BOOT] = rise.boot_complete; // R7
        evt_clk[`CIF_B_PROC_CLK_ERR] = rise.processor_clock_error; // R8
        evt_clk[`CIF_B_SEC_CLK_ERR] = rise.second_domain_clock_error; // R8
        evt_clk[`CIF_B_MAIN_CLK_ERR] = rise.main_clock_error; // R8
        evt_clk[`CIF_B_LOOP_B_LOCK] = rise.loop_b_lock | fall.loop_b_lock; // R9
        evt_clk[`CIF_B_LOOP_A_LOCK] = rise.loop_a_lock | fall.loop_a_lock; // R9
        evt_clk[`CIF_B_LOOP_B_REF] = rise.loop_b_ref_lost; // R10
        evt_clk[`CIF_B_LOOP_A_REF] = rise.loop_a_ref_lost; // R10
        evt_acc[`CIF_B_ACC_B] = rise.accessory_detect_b; // R11
        evt_acc[`CIF_B_ACC_A] = rise.accessory_detect_a; // R11
        evt_acc[`CIF_B_HP_SENSE] = rise.headphone_sense; // R12
        evt_jack[`CIF_B_CLAMP_B_FALL] = fall.clamp_b; // R13
        evt_jack[`CIF_B_CLAMP_B_RISE] = rise.clamp_b; // R13
        evt_jack[`CIF_B_CLAMP_A_FALL] = fall.clamp_a; // R14
        evt_jack[`CIF_B_CLAMP_A_RISE] = rise.clamp_a; // R14
        evt_jack[`CIF_B_JACK_C_FALL] = fall.jack_c; // R15
        evt_jack[`CIF_B_JACK_C_RISE] = rise.jack_c; // R15
        evt_jack[`CIF_B_JACK_B_FALL] = fall.jack_b; // R16
        evt_jack[`CIF_B_JACK_B_RISE] = rise.jack_b; // R16
        evt_jack[`CIF_B_JACK_A_FALL] = fall.jack_a; // R17
        evt_jack[`CIF_B_JACK_A_RISE] = rise.jack_a; // R17
    end

    // write-one clear strobes
    assign clr_sys = (wr && idx == `CIF_IDX_SYS) ? pwdata[15:0] : 16'h0000; // R18
    assign clr_clk = (wr && idx == `CIF_IDX_CLK) ? pwdata[15:0] : 16'h0000; // R18
    assign clr_acc = (wr && idx == `CIF_IDX_ACC) ? pwdata[15:0] : 16'h0000; // R18
    assign clr_jack = (wr && idx == `CIF_IDX_JACK) ? pwdata[15:0] : 16'h0000; // R18

    assign req = (|st.flg_sys) || (|st.flg_clk) || (|st.flg_acc) || (|st.flg_jack); // R19
    assign level = st.cfg[`CIF_CFG_POL] ? req : !req; // R21

    // read data, captured in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            `CIF_IDX_SYS: rd_mux[15:0] = st.flg_sys;
            `CIF_IDX_CLK: rd_mux[15:0] = st.flg_clk;
            `CIF_IDX_ACC: rd_mux[15:0] = st.flg_acc;
            `CIF_IDX_JACK: rd_mux[15:0] = st.flg_jack;
            `CIF_IDX_MSK_SYS: rd_mux[15:0] = st.msk_sys & `CIF_IMPL_SYS;
            `CIF_IDX_MSK_CLK: rd_mux[15:0] = st.msk_clk & `CIF_IMPL_CLK;
            `CIF_IDX_MSK_ACC: rd_mux[15:0] = st.msk_acc & `CIF_IMPL_ACC;
            `CIF_IDX_MSK_JACK: rd_mux[15:0] = st.msk_jack & `CIF_IMPL_JACK;
            `CIF_IDX_CFG: rd_mux[2:0] = st.cfg;
            `CIF_IDX_RAW: rd_mux = {{`CIF_RAW_PAD{1'b0}}, req, st.s2};
            default: rd_mux = 32'h0000_0000;
        endcase
        if (!aligned) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_comb begin
        nx = st;
        // two-stage synchroniser, then the previous sample
        nx.s1 = src_in; // R23
        nx.s2 = st.s1; // R23
        nx.s3 = st.s2; // R23
        // set beats clear; masked sources never set
        nx.flg_sys = ((st.flg_sys & ~clr_sys) | (evt_sys & ~st.msk_sys)) & `CIF_IMPL_SYS; // R18 R20 R22
        nx.flg_clk = ((st.flg_clk & ~clr_clk) | (evt_clk & ~st.msk_clk)) & `CIF_IMPL_CLK; // R18 R20 R22
        nx.flg_acc = ((st.flg_acc & ~clr_acc) | (evt_acc & ~st.msk_acc)) & `CIF_IMPL_ACC; // R18 R20 R22
        nx.flg_jack = ((st.flg_jack & ~clr_jack) | (evt_jack & ~st.msk_jack)) & `CIF_IMPL_JACK; // R18 R20 R22
        if (wr && idx == `CIF_IDX_MSK_SYS) begin
            nx.msk_sys = pwdata[15:0];
        end
        if (wr && idx == `CIF_IDX_MSK_CLK) begin
            nx.msk_clk = pwdata[15:0];
        end
        if (wr && idx == `CIF_IDX_MSK_ACC) begin
            nx.msk_acc = pwdata[15:0];
        end
        if (wr && idx == `CIF_IDX_MSK_JACK) begin
            nx.msk_jack = pwdata[15:0];
        end
        if (wr && idx == `CIF_IDX_CFG) begin
            nx.cfg = pwdata[2:0];
        end
        if (setup_rd) begin
            nx.rdata = rd_mux;
        end
        // open drain pulls low only; push-pull always drives
        nx.pin_out = st.cfg[`CIF_CFG_DRV_OD] ? 1'b0 : level; // R21 R4
        nx.pin_oe = st.cfg[`CIF_CFG_DRV_OD] ? !level : 1'b1; // R21
        nx.gpio_out = st.cfg[`CIF_CFG_GPIO_SEC] ? secondary_request : req; // R2
        nx.sec_prev = secondary_request;
        nx.dsp_start = secondary_request && !st.sec_prev; // R1
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.s1 <= '0;
            st.s2 <= '0;
            st.s3 <= '0;
            st.flg_sys <= `CIF_FLAG_RST; // R18
            st.flg_clk <= `CIF_FLAG_RST;
            st.flg_acc <= `CIF_FLAG_RST;
            st.flg_jack <= `CIF_FLAG_RST;
            st.msk_sys <= `CIF_MSK_SYS_RST; // R3
            st.msk_clk <= `CIF_MSK_ALL_RST; // R3
            st.msk_acc <= `CIF_MSK_ALL_RST; // R3
            st.msk_jack <= `CIF_MSK_ALL_RST; // R3
            st.cfg <= `CIF_CFG_RST;
            st.rdata <= 32'h0000_0000;
            st.pin_out <= 1'b1;
            st.pin_oe <= 1'b1;
            st.gpio_out <= 1'b0;
            st.sec_prev <= 1'b0;
            st.dsp_start <= 1'b0;
        end else begin
            st <= nx;
        end
    end

    assign prdata = st.rdata;
    assign primary_request_pin_out = st.pin_out;
    assign primary_request_pin_oe = st.pin_oe;
    assign gpio_request_out = st.gpio_out;
    assign dsp_start = st.dsp_start;

    // a rising boot edge, unmasked, raises its flag on the next edge
    AST_BOOT_SET: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.boot_complete) && !st.msk_sys[`CIF_B_BOOT]
        |=> st.flg_sys[`CIF_B_BOOT])
        else $error("boot flag not set after boot edge");

    // a masked source never raises its flag
    AST_MASK_BLOCK: assert property ( // R20
        @(posedge pclk) disable iff (!presetn)
        !st.flg_jack[`CIF_B_JACK_A_RISE] && st.msk_jack[`CIF_B_JACK_A_RISE]
        |=> !st.flg_jack[`CIF_B_JACK_A_RISE])
        else $error("masked jack source raised its flag");

    // writing one clears a flag when no new event arrives
    AST_W1C: assert property ( // R18
        @(posedge pclk) disable iff (!presetn)
        clr_clk[`CIF_B_MAIN_CLK_ERR] && !evt_clk[`CIF_B_MAIN_CLK_ERR]
        |=> !st.flg_clk[`CIF_B_MAIN_CLK_ERR])
        else $error("write one did not clear flag");

    // a set flag holds while no clear is written
    AST_HOLD: assert property ( // R18
        @(posedge pclk) disable iff (!presetn)
        st.flg_acc[`CIF_B_HP_SENSE] && !clr_acc[`CIF_B_HP_SENSE]
        |=> st.flg_acc[`CIF_B_HP_SENSE])
        else $error("flag dropped without a clear");

    // an event in the clearing cycle keeps the flag set
    AST_SET_WINS: assert property ( // R22
        @(posedge pclk) disable iff (!presetn)
        clr_jack[`CIF_B_JACK_C_RISE] && evt_jack[`CIF_B_JACK_C_RISE]
        && !st.msk_jack[`CIF_B_JACK_C_RISE]
        |=> st.flg_jack[`CIF_B_JACK_C_RISE])
        else $error("event lost against clear");

    // default push-pull active-low pin follows the request
    AST_PIN_LEVEL: assert property ( // R21
        @(posedge pclk) disable iff (!presetn)
        st.cfg == `CIF_CFG_RST ##1 st.cfg == `CIF_CFG_RST
        |-> primary_request_pin_oe && (primary_request_pin_out == !$past(req)))
        else $error("request pin level wrong");

    // loop lock falling edge raises its flag
    AST_LOCK_FALL: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        $fell(st.s2.loop_a_lock) && !st.msk_clk[`CIF_B_LOOP_A_LOCK]
        |=> st.flg_clk[`CIF_B_LOOP_A_LOCK])
        else $error("loop lock fall not flagged");

    // jack falling edge raises only the fall flag
    AST_JACK_FALL: assert property ( // R17
        @(posedge pclk) disable iff (!presetn)
        $fell(st.s2.jack_a) && !st.msk_jack[`CIF_B_JACK_A_FALL]
        && !st.flg_jack[`CIF_B_JACK_A_RISE] && !clr_jack[`CIF_B_JACK_A_RISE]
        |=> st.flg_jack[`CIF_B_JACK_A_FALL] && !st.flg_jack[`CIF_B_JACK_A_RISE])
        else $error("jack fall flagged wrongly");

    // a synchronised edge appears two cycles after the input
    AST_SYNC: assert property ( // R23
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.jack_b) |-> $past(src_in.jack_b, 2))
        else $error("synchroniser depth wrong");

    // any set clamp or jack flag pulls the default pin low on the next edge
    AST_REQ_OR: assert property ( // R19
        @(posedge pclk) disable iff (!presetn)
        (st.flg_jack != 16'h0000) && (st.cfg == `CIF_CFG_RST)
        |=> !primary_request_pin_out)
        else $error("request missing with flag set");

    // secondary request edge gives one firmware start pulse
    AST_DSP_START: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        $rose(secondary_request) |=> dsp_start ##1 !dsp_start)
        else $error("firmware start pulse wrong");

    // general pin carries the secondary request when that request is selected
    AST_GPIO_ROUTE: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        st.cfg[`CIF_CFG_GPIO_SEC] |=> gpio_request_out == $past(secondary_request))
        else $error("general pin route wrong");

    // with every flag clear the default pin returns high
    AST_REQ_RELEASE: assert property ( // R19
        @(posedge pclk) disable iff (!presetn)
        ((st.flg_sys | st.flg_clk | st.flg_acc | st.flg_jack) == 16'h0000)
        && (st.cfg == `CIF_CFG_RST) |=> primary_request_pin_out)
        else $error("request pin held without a flag");

    // open drain never drives the pin high
    AST_OD_LOW: assert property ( // R21
        @(posedge pclk) disable iff (!presetn)
        st.cfg[`CIF_CFG_DRV_OD] |=> !primary_request_pin_out)
        else $error("open drain pin driven high");

    // host interface error edge raises its flag
    AST_HOST_ERR_SET: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.host_if_error) && !st.msk_sys[`CIF_B_HOST_IF_ERR]
        |=> st.flg_sys[`CIF_B_HOST_IF_ERR])
        else $error("host error flag not set");

    // loop reference lost edge raises its flag
    AST_REF_LOST_SET: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.loop_b_ref_lost) && !st.msk_clk[`CIF_B_LOOP_B_REF]
        |=> st.flg_clk[`CIF_B_LOOP_B_REF])
        else $error("reference lost flag not set");

    // accessory detect event raises its flag
    AST_ACC_SET: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.accessory_detect_a) && !st.msk_acc[`CIF_B_ACC_A]
        |=> st.flg_acc[`CIF_B_ACC_A])
        else $error("accessory flag not set");

    // headphone sense edge raises its flag
    AST_HP_SET: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.headphone_sense) && !st.msk_acc[`CIF_B_HP_SENSE]
        |=> st.flg_acc[`CIF_B_HP_SENSE])
        else $error("headphone flag not set");

    // clamp b falling edge raises its fall flag
    AST_CLAMP_B_FALL: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        $fell(st.s2.clamp_b) && !st.msk_jack[`CIF_B_CLAMP_B_FALL]
        |=> st.flg_jack[`CIF_B_CLAMP_B_FALL])
        else $error("clamp b fall not flagged");

    // clamp a rising edge raises its rise flag
    AST_CLAMP_A_RISE: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.clamp_a) && !st.msk_jack[`CIF_B_CLAMP_A_RISE]
        |=> st.flg_jack[`CIF_B_CLAMP_A_RISE])
        else $error("clamp a rise not flagged");

    // jack c falling edge raises its fall flag
    AST_JACK_C_FALL: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        $fell(st.s2.jack_c) && !st.msk_jack[`CIF_B_JACK_C_FALL]
        |=> st.flg_jack[`CIF_B_JACK_C_FALL])
        else $error("jack c fall not flagged");

    // jack b rising edge raises its rise flag
    AST_JACK_B_RISE: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        $rose(st.s2.jack_b) && !st.msk_jack[`CIF_B_JACK_B_RISE]
        |=> st.flg_jack[`CIF_B_JACK_B_RISE])
        else $error("jack b rise not flagged");

endmodule // cif_primary_request_event_flags

`default_nettype wire

// ===== design/cif_defines.svh
// register indices, bit positions, reset values and layout constants
`ifndef CIF_DEFINES_SVH
`define CIF_DEFINES_SVH

// register indices; the byte address is four times the index
`define CIF_IDX_SYS 14'h1800
`define CIF_IDX_CLK 14'h1801
`define CIF_IDX_ACC 14'h1805
`define CIF_IDX_JACK 14'h1806
`define CIF_IDX_MSK_SYS 14'h1810
`define CIF_IDX_MSK_CLK 14'h1811
`define CIF_IDX_MSK_ACC 14'h1815
`define CIF_IDX_MSK_JACK 14'h1816
`define CIF_IDX_CFG 14'h1820
`define CIF_IDX_RAW 14'h1821

// flag bit positions in the system register
`define CIF_B_HOST_IF_ERR 12
`define CIF_B_CLK_FAIL 9
`define CIF_B_BOOT 7
// flag bit positions in the clock and loop register
`define CIF_B_PROC_CLK_ERR 14
`define CIF_B_SEC_CLK_ERR 13
`define CIF_B_MAIN_CLK_ERR 12
`define CIF_B_LOOP_B_LOCK 9
`define CIF_B_LOOP_A_LOCK 8
`define CIF_B_LOOP_B_REF 6
`define CIF_B_LOOP_A_REF 5
// flag bit positions in the accessory register
`define CIF_B_ACC_B 9
`define CIF_B_ACC_A 8
`define CIF_B_HP_SENSE 0
// flag bit positions in the clamp and jack register
`define CIF_B_CLAMP_B_FALL 11
`define CIF_B_CLAMP_B_RISE 10
`define CIF_B_JACK_C_FALL 9
`define CIF_B_JACK_C_RISE 8
`define CIF_B_CLAMP_A_FALL 5
`define CIF_B_CLAMP_A_RISE 4
`define CIF_B_JACK_B_FALL 3
`define CIF_B_JACK_B_RISE 2
`define CIF_B_JACK_A_FALL 1
`define CIF_B_JACK_A_RISE 0

// implemented flag bits per register
`define CIF_IMPL_SYS 16'h1280
`define CIF_IMPL_CLK 16'h7360
`define CIF_IMPL_ACC 16'h0301
`define CIF_IMPL_JACK 16'h0F3F

// reset values
`define CIF_FLAG_RST 16'h0000
`define CIF_MSK_SYS_RST 16'hFF7F
`define CIF_MSK_ALL_RST 16'hFFFF
`define CIF_CFG_RST 3'h0

// configuration bits
`define CIF_CFG_POL 0
`define CIF_CFG_DRV_OD 1
`define CIF_CFG_GPIO_SEC 2

// raw status layout
`define CIF_RAW_REQ 18
`define CIF_RAW_PAD 13

`endif

// ===== design/cif_pkg.sv
// types shared by the first-request event flag block
package cif_pkg;

    // one bit per interrupt source, in raw status order (msb first)
    typedef struct packed {
        logic host_if_error;
        logic main_clock_fail;
        logic boot_complete;
        logic processor_clock_error;
        logic second_domain_clock_error;
        logic main_clock_error;
        logic loop_b_lock;
        logic loop_a_lock;
        logic loop_b_ref_lost;
        logic loop_a_ref_lost;
        logic accessory_detect_b;
        logic accessory_detect_a;
        logic headphone_sense;
        logic clamp_b;
        logic clamp_a;
        logic jack_c;
        logic jack_b;
        logic jack_a;
    } cif_src_t;

    typedef struct packed {
        cif_src_t s1;
        cif_src_t s2;
        cif_src_t s3;
        logic [15:0] flg_sys;
        logic [15:0] flg_clk;
        logic [15:0] flg_acc;
        logic [15:0] flg_jack;
        logic [15:0] msk_sys;
        logic [15:0] msk_clk;
        logic [15:0] msk_acc;
        logic [15:0] msk_jack;
        logic [2:0] cfg;
        logic [31:0] rdata;
        logic pin_out;
        logic pin_oe;
        logic gpio_out;
        logic sec_prev;
        logic dsp_start;
    } cif_state_t;

endpackage

// ===== dv/cif_host_pin.sv
// host-side model of the request pin wire and its edge watcher
`timescale 1ns/1ps
`default_nettype none

module cif_host_pin (
    // pin as driven by the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // resolved wire and falling edges seen by the host
    output logic pin_wire,
    output var int falls
);
    // board pull-up holds the line high when nobody drives it
    assign pin_wire = pin_oe ? pin_out : 1'b1;
    initial falls = 0;
    // host takes each falling edge as an event, the first as boot complete
    always @(negedge pin_wire) falls++;
endmodule // cif_host_pin
`default_nettype wire

// ===== dv/cif_primary_request_event_flags_tb.sv
// self-checking bench for the first-request event flag block
`timescale 1ns/1ps
`include "cif_defines.svh"
`default_nettype none

module cif_primary_request_event_flags_tb;
    import cif_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, secondary_request;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pin_out, pin_oe, gpio_out, dsp_start, pin_wire, err;
    cif_src_t src_in;
    int miscompares = 0;
    int num_checks = 0;
    int falls;
    // per source bit: rising and falling flag bit, -1 where none
    int rbit [18] = '{0, 2, 8, 4, 10, 0, 8, 9, 5, 6, 8, 9, 12, 13, 14, 7, 9, 12};
    int fbit [18] = '{1, 3, 9, 5, 11, -1, -1, -1, -1, -1, 8, 9, -1, -1, -1, -1, -1, -1};
    logic [13:0] fl [4] = '{`CIF_IDX_SYS, `CIF_IDX_CLK, `CIF_IDX_ACC, `CIF_IDX_JACK};
    logic [13:0] mk [4] = '{`CIF_IDX_MSK_SYS, `CIF_IDX_MSK_CLK, `CIF_IDX_MSK_ACC, `CIF_IDX_MSK_JACK};
    logic [31:0] mexp [4] = '{32'h00001200, 32'h00007360, 32'h00000301, 32'h00000F3F};

    cif_primary_request_event_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_in(src_in), .secondary_request(secondary_request),
        .primary_request_pin_out(pin_out), .primary_request_pin_oe(pin_oe),
        .gpio_request_out(gpio_out), .dsp_start(dsp_start));

    cif_host_pin i_host (.pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_wire),
        .falls(falls));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [15:0] ba(input logic [13:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [13:0] reg_of(input int i);
        if (i < 5) return `CIF_IDX_JACK;
        if (i < 8) return `CIF_IDX_ACC;
        if (i < 15) return `CIF_IDX_CLK;
        return `CIF_IDX_SYS;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        src_in = '0;
        secondary_request = 1'b0;
        tick(4);
        presetn <= 1'b1;
        tick(1);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ba(fl[k]), '0);
            check(rd, '0);
            apb(1'b0, ba(mk[k]), '0);
            check(rd, mexp[k]);
        end
        check(32'(pin_wire), 32'h1);
        // masked source, then the only unmasked one
        src_in.jack_a <= 1'b1;
        tick(6);
        apb(1'b0, ba(`CIF_IDX_JACK), '0);
        check(rd, '0);
        src_in.boot_complete <= 1'b1;
        tick(6);
        apb(1'b0, ba(`CIF_IDX_SYS), '0);
        check(rd, 32'h00000080);
        check(32'(pin_wire), 32'h0);
        check(32'(falls), 32'h1);
        apb(1'b0, ba(`CIF_IDX_RAW), '0);
        check(rd, 32'h00048001);
        apb(1'b1, ba(`CIF_IDX_SYS), 32'h00000080);
        src_in <= '0;
        tick(6);
        for (int k = 0; k < 4; k++) apb(1'b1, ba(mk[k]), '0);
        // every source, each qualifying edge
        for (int i = 0; i < 18; i++) begin
            src_in[i] <= 1'b1;
            tick(6);
            apb(1'b0, ba(reg_of(i)), '0);
            check(rd, 32'h1 << rbit[i]);
            check(32'(pin_wire), 32'h0);
            apb(1'b1, ba(reg_of(i)), '0);
            apb(1'b0, ba(reg_of(i)), '0);
            check(rd, 32'h1 << rbit[i]);
            apb(1'b1, ba(reg_of(i)), 32'h1 << rbit[i]);
            apb(1'b0, ba(reg_of(i)), '0);
            check(rd, '0);
            check(32'(pin_wire), 32'h1);
            src_in[i] <= 1'b0;
            tick(6);
            apb(1'b0, ba(reg_of(i)), '0);
            check(rd, (fbit[i] < 0) ? '0 : 32'h1 << fbit[i]);
            apb(1'b1, ba(reg_of(i)), rd);
        end
        // new edge lands on the same edge as its clear
        src_in.jack_c <= 1'b1;
        tick(1);
        apb(1'b1, ba(`CIF_IDX_JACK), 32'h00000100);
        apb(1'b0, ba(`CIF_IDX_JACK), '0);
        check(rd, 32'h00000100);
        apb(1'b1, ba(`CIF_IDX_CFG), 32'h1);
        tick(2);
        check(32'(pin_out), 32'h1);
        apb(1'b1, ba(`CIF_IDX_CFG), 32'h2);
        tick(2);
        check(32'({pin_out, pin_oe, gpio_out}), 32'h3);
        src_in.jack_c <= 1'b0;
        tick(6);
        apb(1'b1, ba(`CIF_IDX_JACK), 32'h00000300);
        tick(2);
        check(32'({pin_oe, pin_wire, gpio_out}), 32'h2);
        apb(1'b1, ba(`CIF_IDX_CFG), 32'h4);
        secondary_request <= 1'b1;
        @(posedge pclk);
        #1 check(32'(dsp_start), 32'h1);
        @(posedge pclk);
        #1 check(32'({dsp_start, gpio_out}), 32'h1);
        @(posedge pclk);
        secondary_request <= 1'b0;
        // refused accesses, then a raw status write accepted without error
        apb(1'b0, ba(14'h1802), '0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, ba(`CIF_IDX_CFG) | 16'h0001, 32'h7);
        check(32'(err), 32'h1);
        apb(1'b0, ba(`CIF_IDX_CFG), '0);
        check(rd, 32'h4);
        apb(1'b1, ba(`CIF_IDX_RAW), '1);
        check(32'(err), 32'h0);
        tick(2);
        wrap_up();
    end
endmodule // cif_primary_request_event_flags_tb
`default_nettype wire
